// file: common/elog_pkg.sv
// package: constants and types of the error log record builder
package elog_pkg;
	// ------------------------------------------------------------
	// clock and time
	// ------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;           // pclk rate
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S; // cycles per millisecond
	localparam int MS_PER_HOUR = 3_600_000;        // milliseconds per hour

	// ------------------------------------------------------------
	// log geometry
	// ------------------------------------------------------------
	localparam int SECTORS = 51;                   // sectors of the log
	localparam int RECS_PER_SEC = 5;               // records per sector
	localparam int LOG_RECS = SECTORS * RECS_PER_SEC;
	localparam int REC_BYTES = 90;                 // bytes per record
	localparam int CMD_BYTES = 12;                 // bytes per command snapshot
	localparam int HIST_DEPTH = 5;                 // command snapshots per record
	localparam int ERR_BYTES = 30;                 // bytes of the error snapshot
	localparam int EXT_BYTES = 19;                 // extended error detail bytes
	localparam int MEM_BYTES = LOG_RECS * REC_BYTES;
	localparam int MEM_AW = 15;
	localparam int CMD_W = CMD_BYTES * 8;
	localparam int HIST_W = CMD_W * HIST_DEPTH;
	localparam int ERR_W = ERR_BYTES * 8;
	localparam int REC_W = REC_BYTES * 8;

	// ------------------------------------------------------------
	// sector byte offsets and fixed contents
	// ------------------------------------------------------------
	localparam logic [8:0] OFF_VERSION = 9'h000;
	localparam logic [8:0] OFF_INDEX = 9'h001;
	localparam logic [8:0] OFF_REC = 9'h002;       // first record byte
	localparam logic [8:0] OFF_ECNT_LO = 9'h1c4;   // byte 452
	localparam logic [8:0] OFF_ECNT_HI = 9'h1c5;   // byte 453
	localparam logic [8:0] OFF_CSUM = 9'h1ff;      // byte 511
	localparam logic [7:0] LOG_VERSION = 8'h01;
	localparam logic [3:0] STATE_HI = 4'h0;        // upper nibble of state byte
	localparam logic [7:0] RST_CMD = 8'h00;        // command byte of a reset entry
	localparam logic [15:0] ERRCNT_MAX = 16'hffff;

	// ------------------------------------------------------------
	// apb register map
	// ------------------------------------------------------------
	localparam logic [11:0] A_STATUS = 12'h000;
	localparam logic [11:0] A_SECSEL = 12'h004;
	localparam logic [11:0] A_ERRCNT = 12'h008;
	localparam logic [11:0] A_HOURS = 12'h00c;
	localparam logic [11:0] A_MSCNT = 12'h010;
	localparam int WIN_BIT = 11;                   // set: sector byte window
	localparam int STATUS_BUSY = 0;
	localparam int STATUS_IDX = 8;
	localparam logic [5:0] SECSEL_RST = 6'h00;

	// ------------------------------------------------------------
	// record builder states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_WRITE = 2'b01,
		B_COMMIT = 2'b10
	} build_state_t;
endpackage

// file: common/elog_if.sv
// interfaces: record memory port and command history port
interface elog_ram_if;
	import elog_pkg::*;
	logic we;                  // write strobe
	logic [MEM_AW-1:0] waddr;  // write byte address
	logic [7:0] wdata;         // write byte
	logic [MEM_AW-1:0] raddr;  // read byte address
	logic [7:0] rdata;         // registered read byte
	modport mem (input we, waddr, wdata, raddr, output rdata);
	modport user (output we, waddr, wdata, raddr, input rdata);
endinterface

interface elog_hist_if;
	import elog_pkg::*;
	logic push;                // a command or reset was taken
	logic [CMD_W-1:0] entry;   // its 12-byte snapshot, byte 0 lowest
	logic [HIST_W-1:0] img;    // five snapshots, oldest first, unused zero
	modport owner (input push, entry, output img);
	modport user (output push, entry, input img);
endinterface

// file: design/elog_ram.sv
// record memory: one write port, one registered read port
module elog_ram
	import elog_pkg::*;
(
	// clock
	input wire logic pclk,
	// access port
	elog_ram_if.mem m
);
	logic [7:0] mem [MEM_BYTES]; // record bytes, no reset

	// write and registered read
	always_ff @(posedge pclk) begin
		if (m.we) begin
			mem[m.waddr] <= m.wdata;
		end
		m.rdata <= mem[m.raddr];
	end
endmodule

// file: design/elog_hist.sv
// command history: last five command or reset snapshots
module elog_hist
	import elog_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// history port
	elog_hist_if.owner h
);
	logic [CMD_W-1:0] ent [HIST_DEPTH]; // entry 0 oldest
	logic [HIST_DEPTH-1:0] vld;         // entry holds a real snapshot

	// shift in a new snapshot, oldest falls out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vld <= '0;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				ent[i] <= '0;
			end
		end else if (h.push) begin
			for (int i = 0; i < HIST_DEPTH - 1; i++) begin
				ent[i] <= ent[i+1];
			end
			ent[HIST_DEPTH-1] <= h.entry;
			vld <= {1'b1, vld[HIST_DEPTH-1:1]};
		end
	end

	// missing snapshots read as zero
	always_comb begin
		for (int i = 0; i < HIST_DEPTH; i++) begin
			h.img[i*CMD_W +: CMD_W] = vld[i] ? ent[i] : '0;
		end
	end
endmodule

// file: design/elog_builder.sv
// error log record builder: snapshots, record memory, sector readout over apb
//
// Contract
// - command snapshot holds task file and command
// - snapshot bytes 8-11 hold wrapping milliseconds
// - error snapshot holds registers after completion
// - extended error bytes are implementation defined
// - state byte low nibble encodes power state
// - state byte high nibble implementation defined
// - state taken when command or reset arrived
// - bytes 28-29 hold lifetime hours at completion
// - count counts device-attributable errors
// - host-caused errors never counted
// - error count saturates at maximum
// - byte 511 is negated sum of bytes
// - sum is unsigned, carries dropped
// - log covers 28-bit commands, 51 sectors
// - sector zero layout: version, index, count
// - later sectors hold records 5n+1 to 5n+5
// - only device errors create records
// - index names latest record, zero if none
// - log wraps to first record when full
// - unused records and snapshots read zero
//
// The APB slave port and the address map were left to the implementer.
module elog_builder
	import elog_pkg::*;
#(
	parameter int CYC_PER_MS_P = CYC_PER_MS,
	parameter int MS_PER_HOUR_P = MS_PER_HOUR
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// task file when a command is written
	input wire logic cmd_strobe,
	input wire logic srst_strobe,
	input wire logic [7:0] tf_devctl,
	input wire logic [7:0] tf_features,
	input wire logic [7:0] tf_seccnt,
	input wire logic [7:0] tf_secnum,
	input wire logic [7:0] tf_cyllo,
	input wire logic [7:0] tf_cylhi,
	input wire logic [7:0] tf_devhead,
	input wire logic [7:0] tf_cmd,
	input wire logic [3:0] pwr_state,
	// command completion
	input wire logic done_strobe,
	input wire logic done_dev_err,
	input wire logic done_host_err,
	input wire logic [7:0] done_error,
	input wire logic [7:0] done_seccnt,
	input wire logic [7:0] done_secnum,
	input wire logic [7:0] done_cyllo,
	input wire logic [7:0] done_cylhi,
	input wire logic [7:0] done_devhead,
	input wire logic [7:0] done_status
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	elog_ram_if ram ();
	elog_hist_if hist ();

	logic [31:0] div_cnt;              // cycles within a millisecond
	logic ms_tick;                     // one-cycle millisecond enable
	logic [31:0] ms_count;             // milliseconds since power-on
	logic [31:0] hour_ms;              // milliseconds within an hour
	logic hour_tick;                   // one-cycle hour enable
	logic [15:0] hours;                // lifetime hours
	logic [15:0] errcnt;               // device error count
	logic [3:0] state_cap;             // power state at last command
	logic err_evt;                     // qualifying device error
	build_state_t bstate;              // record builder state
	logic [REC_W-1:0] rec_img;         // record being written
	logic [7:0] wr_slot;               // slot being written
	logic [6:0] wr_byte;               // byte within record
	logic [7:0] wr_acc;                // running byte sum of record
	logic [7:0] idx;                   // latest record number, 0 = none
	logic [LOG_RECS-1:0] rec_valid;    // slot holds a finished record
	logic [7:0] rec_sum [LOG_RECS];    // byte sum of each finished record
	logic [5:0] secsel;                // sector shown in the window
	logic ack;                         // access phase answered
	logic acc_ph;                      // apb access phase
	logic wr_fire;                     // register write takes effect
	logic [31:0] rd_val;               // read mux
	logic rd_err;                      // read of unmapped address
	logic wr_bad;                      // write refused
	logic [8:0] off;                   // byte offset within sector
	logic [2:0] rec_r;                 // record within sector
	logic [6:0] rec_b;                 // byte within that record
	logic in_rec;                      // offset lies in the record area
	logic [7:0] rd_slot;               // slot seen by the window
	logic [7:0] sec_sum;               // sum of bytes 0..510 of the sector
	logic [7:0] win;                   // window byte

	// first memory byte of a slot
	function automatic logic [MEM_AW-1:0] rec_base(input logic [7:0] slot);
		rec_base = MEM_AW'(slot) * MEM_AW'(REC_BYTES);
	endfunction

	elog_ram u_ram (
		.pclk (pclk),
		.m (ram.mem)
	);

	elog_hist u_hist (
		.pclk (pclk),
		.presetn (presetn),
		.h (hist.owner)
	);

	// ------------------------------------------------------------
	// time base
	// ------------------------------------------------------------
	assign ms_tick = (div_cnt == 32'(CYC_PER_MS_P - 1));
	assign hour_tick = ms_tick && (hour_ms == 32'(MS_PER_HOUR_P - 1));

	// millisecond divider and counter, cleared at power-on, wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= '0;
			ms_count <= '0;
		end else begin
			div_cnt <= ms_tick ? '0 : div_cnt + 32'h0000_0001;
			if (ms_tick) begin
				ms_count <= ms_count + 32'h0000_0001;
			end
		end
	end

	// hour divider and lifetime hours, reloaded by software after power-on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hour_ms <= '0;
			hours <= '0;
		end else begin
			if (ms_tick) begin
				hour_ms <= hour_tick ? '0 : hour_ms + 32'h0000_0001;
			end
			if (wr_fire && paddr == A_HOURS) begin
				hours <= pwdata[15:0];
			end else if (hour_tick) begin
				hours <= hours + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// command snapshots
	// ------------------------------------------------------------
	assign hist.push = cmd_strobe | srst_strobe;
	// byte 0 lowest: task file, command, then milliseconds low byte first
	assign hist.entry = {ms_count, srst_strobe ? RST_CMD : tf_cmd, tf_devhead,
		tf_cylhi, tf_cyllo, tf_secnum, tf_seccnt, tf_features, tf_devctl};

	// power state as it stood when the command or reset arrived
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_cap <= '0;
		end else if (hist.push) begin
			state_cap <= pwr_state;
		end
	end

	// ------------------------------------------------------------
	// error count
	// ------------------------------------------------------------
	// host-caused failures neither count nor log
	assign err_evt = done_strobe & done_dev_err & ~done_host_err;

	// load from software first, then count the event on top of it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			errcnt <= '0;
		end else begin
			if (wr_fire && paddr == A_ERRCNT) begin
				errcnt <= (err_evt && pwdata[15:0] != ERRCNT_MAX) ?
					pwdata[15:0] + 16'h0001 : pwdata[15:0];
			end else if (err_evt && errcnt != ERRCNT_MAX) begin
				errcnt <= errcnt + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// record builder
	// ------------------------------------------------------------
	assign ram.we = (bstate == B_WRITE);
	assign ram.waddr = rec_base(wr_slot) + MEM_AW'(wr_byte);
	assign ram.wdata = rec_img[wr_byte*8 +: 8];

	// capture one record, stream it into memory, then publish it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bstate <= B_IDLE;
			rec_img <= '0;
			wr_slot <= '0;
			wr_byte <= '0;
			wr_acc <= '0;
			idx <= '0;
			rec_valid <= '0;
		end else begin
			case (bstate)
				B_IDLE: begin
					if (err_evt) begin
						// error snapshot above the five command snapshots
						rec_img <= {hours, STATE_HI, state_cap,
							{(EXT_BYTES*8){1'b0}},
							done_status, done_devhead, done_cylhi, done_cyllo,
							done_secnum, done_seccnt, done_error, 8'h00,
							hist.img};
						// next slot wraps after the last one
						wr_slot <= (idx == 8'(LOG_RECS)) ? 8'h00 : idx;
						rec_valid[(idx == 8'(LOG_RECS)) ? 8'h00 : idx] <= 1'b0;
						wr_byte <= '0;
						wr_acc <= '0;
						bstate <= B_WRITE;
					end
				end
				B_WRITE: begin
					wr_acc <= wr_acc + ram.wdata;
					if (wr_byte == 7'(REC_BYTES - 1)) begin
						bstate <= B_COMMIT;
					end else begin
						wr_byte <= wr_byte + 7'h01;
					end
				end
				B_COMMIT: begin
					rec_valid[wr_slot] <= 1'b1;
					idx <= wr_slot + 8'h01;
					bstate <= B_IDLE;
				end
				default: begin
					bstate <= B_IDLE;
				end
			endcase
		end
	end

	// per-record sums keep the checksum free of a sector scan
	always_ff @(posedge pclk) begin
		if (bstate == B_COMMIT) begin
			rec_sum[wr_slot] <= wr_acc;
		end
	end

	// ------------------------------------------------------------
	// sector window
	// ------------------------------------------------------------
	// locate the record and byte behind a sector offset
	always_comb begin
		off = paddr[10:2];
		rec_r = 3'h0;
		for (int i = 1; i < RECS_PER_SEC; i++) begin
			if (off >= 9'(OFF_REC + i * REC_BYTES)) begin
				rec_r = 3'(i);
			end
		end
		in_rec = (off >= OFF_REC) && (off < 9'(OFF_REC + RECS_PER_SEC * REC_BYTES));
		rec_b = 7'(off - OFF_REC - 9'(rec_r * REC_BYTES));
		rd_slot = 8'(secsel * RECS_PER_SEC + rec_r);
	end

	assign ram.raddr = rec_base(rd_slot) + MEM_AW'(rec_b);

	// sum of bytes 0..510, header only in sector zero
	always_comb begin
		logic [7:0] s;
		s = '0;
		sec_sum = '0;
		for (int i = 0; i < RECS_PER_SEC; i++) begin
			s = 8'(secsel * RECS_PER_SEC + i);
			if (rec_valid[s]) begin
				sec_sum = sec_sum + rec_sum[s];
			end
		end
		if (secsel == '0) begin
			sec_sum = sec_sum + LOG_VERSION + idx + errcnt[7:0] + errcnt[15:8];
		end
	end

	// byte of the selected sector at the current offset
	always_comb begin
		if (off == OFF_CSUM) begin
			win = 8'h00 - sec_sum;
		end else if (in_rec) begin
			win = rec_valid[rd_slot] ? ram.rdata : 8'h00;
		end else if (secsel == '0) begin
			case (off)
				OFF_VERSION: win = LOG_VERSION;
				OFF_INDEX: win = idx;
				OFF_ECNT_LO: win = errcnt[7:0];
				OFF_ECNT_HI: win = errcnt[15:8];
				default: win = 8'h00;
			endcase
		end else begin
			win = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	assign acc_ph = psel & penable;
	assign pready = ack;
	assign wr_fire = acc_ph & ack & pwrite & ~pslverr;

	// register read mux and write check
	always_comb begin
		rd_val = '0;
		rd_err = 1'b0;
		if (paddr[WIN_BIT]) begin
			rd_val = {24'h00_0000, win};
		end else begin
			case (paddr)
				A_STATUS: begin
					rd_val[STATUS_BUSY] = (bstate != B_IDLE);
					rd_val[STATUS_IDX +: 8] = idx;
				end
				A_SECSEL: rd_val = {26'h000_0000, secsel};
				A_ERRCNT: rd_val = {16'h0000, errcnt};
				A_HOURS: rd_val = {16'h0000, hours};
				A_MSCNT: rd_val = ms_count;
				default: rd_err = 1'b1;
			endcase
		end
		wr_bad = !((paddr == A_SECSEL && pwdata < 32'(SECTORS)) ||
			paddr == A_ERRCNT || paddr == A_HOURS);
	end

	// one wait state: memory data settle before the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			ack <= acc_ph & ~ack;
			if (acc_ph && !ack) begin
				prdata <= pwrite ? '0 : rd_val;
				pslverr <= pwrite ? wr_bad : rd_err;
			end
		end
	end

	// sector select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			secsel <= SECSEL_RST;
		end else if (wr_fire && paddr == A_SECSEL) begin
			secsel <= pwdata[5:0];
		end
	end
endmodule

// file: sim/elog_builder_asserts.sv
// checker: port-level properties of the error log builder
module elog_checker
	import elog_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// completion
	input wire logic done_strobe,
	input wire logic done_dev_err,
	input wire logic done_host_err
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	logic rd; // read handshake
	logic wr; // write handshake
	logic win; // sector byte window
	logic [8:0] k; // window byte number
	logic ev; // counted device error
	logic [5:0] sec; // sector shown
	logic [15:0] cnt; // expected error count
	logic seen; // an error was taken since reset
	assign rd = psel && penable && pready && !pwrite;
	assign wr = psel && penable && pready && pwrite;
	assign win = paddr[WIN_BIT];
	assign k = paddr[10:2];
	assign ev = done_strobe && done_dev_err && !done_host_err;
	// expected sector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec <= SECSEL_RST;
		end else if (wr && paddr == A_SECSEL && pwdata < SECTORS) begin
			sec <= pwdata[5:0];
		end
	end
	// expected count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0000;
		end else if (wr && paddr == A_ERRCNT) begin
			cnt <= pwdata[15:0];
		end else if (ev && cnt != ERRCNT_MAX) begin
			cnt <= cnt + 16'h0001;
		end
	end
	// any counted error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen <= 1'b0;
		end else if (ev) begin
			seen <= 1'b1;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_one_wait;
		$rose(penable) && psel |-> !pready ##1 pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
	property p_secsel_refuse;
		wr && paddr == A_SECSEL && pwdata >= SECTORS |-> pslverr;
	endproperty
	a_secsel_refuse: assert property (p_secsel_refuse) else $error("bad sector taken");
	property p_version;
		rd && win && sec == 6'h00 && k == OFF_VERSION |-> prdata == 32'(LOG_VERSION);
	endproperty
	a_version: assert property (p_version) else $error("version byte wrong");
	property p_later_hdr;
		rd && win && sec != 6'h00 && (k < OFF_REC || k == OFF_ECNT_LO || k == OFF_ECNT_HI)
			|-> prdata == 32'h0;
	endproperty
	a_later_hdr: assert property (p_later_hdr) else $error("later header nonzero");
	property p_tail;
		rd && win && k >= 9'h1c6 && k <= 9'h1fe |-> prdata == 32'h0;
	endproperty
	a_tail: assert property (p_tail) else $error("reserved tail nonzero");
	property p_cnt_lo;
		rd && win && sec == 6'h00 && k == OFF_ECNT_LO |-> prdata == 32'(cnt[7:0]);
	endproperty
	a_cnt_lo: assert property (p_cnt_lo) else $error("count low byte wrong");
	property p_cnt_hi;
		rd && win && sec == 6'h00 && k == OFF_ECNT_HI |-> prdata == 32'(cnt[15:8]);
	endproperty
	a_cnt_hi: assert property (p_cnt_hi) else $error("count high byte wrong");
	property p_errcnt;
		rd && paddr == A_ERRCNT |-> prdata == 32'(cnt);
	endproperty
	a_errcnt: assert property (p_errcnt) else $error("error count wrong");
	property p_sat;
		rd && paddr == A_ERRCNT && cnt == ERRCNT_MAX |-> prdata[15:0] == ERRCNT_MAX;
	endproperty
	a_sat: assert property (p_sat) else $error("count left max");
	property p_idx0;
		rd && paddr == A_STATUS && !seen |-> prdata[15:8] == 8'h00;
	endproperty
	a_idx0: assert property (p_idx0) else $error("index nonzero with empty log");
endmodule

bind elog_builder elog_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready,
	.pslverr, .done_strobe, .done_dev_err, .done_host_err);

// file: sim/ata_host.sv
// host model: apb master that fetches log sectors
module ata_host
	import elog_pkg::*;
(
	// clock
	input wire logic pclk,
	// apb master side
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sec_buf [512]; // last sector fetched
	int hung = 0; // waits that ran out
	// little-endian word of the fetched sector
	function automatic logic [31:0] word(input int i);
		word = {sec_buf[i+3], sec_buf[i+2], sec_buf[i+1], sec_buf[i]};
	endfunction
	// one transfer, held until ready is sampled or 16 cycles pass
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 16) hung++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// fetch a sector, sum all its bytes
	task automatic fetch(input logic [5:0] s, output logic [7:0] sum);
		logic [31:0] r;
		logic e;
		xfer(1'b1, A_SECSEL, 32'(s), r, e);
		sum = 8'h00;
		for (int k = 0; k < 512; k++) begin
			xfer(1'b0, 12'h800 + 12'(4 * k), 32'h0, r, e);
			sec_buf[k] = r[7:0];
			sum = sum + r[7:0];
		end
	endtask
endmodule

// file: sim/testbench.sv
// testbench: rows, records, wrap, resets
module testbench
	import elog_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic e;
	logic [7:0] sum;
	logic cmd_strobe = 1'b0, srst_strobe = 1'b0, done_strobe = 1'b0;
	logic done_dev_err = 1'b0, done_host_err = 1'b0;
	logic [3:0] pwr_state = 4'h0;
	logic [7:0] tf [8] = '{default: 8'h00}; // task file at command
	logic [7:0] dn [7] = '{default: 8'h00}; // registers at completion
	int n_fail = 0;
	int comparisons = 0;
	// register accesses: refusals, reset values, loads
	row_t rows [12] = '{
		'{1'b0, A_STATUS, 32'h0, 32'h0, 1'b0}, '{1'b0, A_SECSEL, 32'h0, 32'h0, 1'b0},
		'{1'b0, A_ERRCNT, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h014, 32'h0, 32'h0, 1'b1},
		'{1'b0, 12'h7fc, 32'h0, 32'h0, 1'b1}, '{1'b1, A_STATUS, 32'h1, 32'h0, 1'b1},
		'{1'b1, A_SECSEL, 32'h33, 32'h0, 1'b1}, '{1'b0, A_SECSEL, 32'h0, 32'h0, 1'b0},
		'{1'b1, A_SECSEL, 32'h32, 32'h0, 1'b0}, '{1'b0, A_SECSEL, 32'h0, 32'h32, 1'b0},
		'{1'b1, A_HOURS, 32'h1234, 32'h0, 1'b0}, '{1'b0, A_HOURS, 32'h0, 32'h1234, 1'b0}};
	always #4 pclk = ~pclk;
	elog_builder #(.CYC_PER_MS_P(4), .MS_PER_HOUR_P(3_600_000)) i_dut (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_strobe,
		.srst_strobe, .tf_devctl(tf[0]), .tf_features(tf[1]), .tf_seccnt(tf[2]),
		.tf_secnum(tf[3]), .tf_cyllo(tf[4]), .tf_cylhi(tf[5]), .tf_devhead(tf[6]),
		.tf_cmd(tf[7]), .pwr_state, .done_strobe, .done_dev_err, .done_host_err,
		.done_error(dn[0]), .done_seccnt(dn[1]), .done_secnum(dn[2]), .done_cyllo(dn[3]),
		.done_cylhi(dn[4]), .done_devhead(dn[5]), .done_status(dn[6]));
	ata_host i_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	// compare a value and count it
	task automatic chk(input string what, input logic [31:0] x, input logic [31:0] y);
		comparisons++;
		if (y !== x) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, x, y);
		end
	endtask
	// compare one fetched sector byte
	task automatic chkb(input string what, input logic [7:0] x, input int i);
		chk(what, 32'(x), 32'(i_host.sec_buf[i]));
	endtask
	// command or reset entry, then power state moves on
	task automatic issue(input logic [3:0] j, input logic [3:0] st, input logic rst);
		@(posedge pclk);
		for (int i = 0; i < 8; i++) tf[i] <= {j, i[3:0]};
		pwr_state <= st;
		cmd_strobe <= !rst;
		srst_strobe <= rst;
		@(posedge pclk);
		cmd_strobe <= 1'b0;
		srst_strobe <= 1'b0;
		pwr_state <= 4'h9;
	endtask
	// completion, then wait out the build
	task automatic complete(input logic dev, input logic host, input logic [7:0] e0);
		@(posedge pclk);
		dn[0] <= e0;
		for (int i = 1; i < 7; i++) dn[i] <= {e0[3:0], i[3:0]};
		done_dev_err <= dev;
		done_host_err <= host;
		done_strobe <= 1'b1;
		@(posedge pclk);
		done_strobe <= 1'b0;
		repeat (94) @(posedge pclk);
	endtask
	// check one record of the fetched sector
	task automatic chk_rec(input int b, input logic [3:0] j, input logic [3:0] st,
		input logic [7:0] e0, input logic rst);
		for (int i = 0; i < 8; i++) chkb("snap", (i == 7 && rst) ? 8'h00 : {j, i[3:0]}, b + 48 + i);
		chkb("rsvd", 8'h00, b + 60);
		chkb("error", e0, b + 61);
		for (int i = 1; i < 7; i++) chkb("after", {e0[3:0], i[3:0]}, b + 61 + i);
		for (int i = 68; i < 87; i++) chkb("ext", 8'h00, b + i);
		chkb("state", {STATE_HI, st}, b + 87);
		chkb("hours", 8'h34, b + 88);
		chkb("hours", 8'h12, b + 89);
	endtask
	// closing report
	task automatic tally_and_finish();
		n_fail += i_host.hung;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			i_host.xfer(rows[i].w, rows[i].a, rows[i].d, r, e);
			if (!rows[i].w && !rows[i].e) chk("reg", rows[i].q, r);
			chk("refusal", 32'(rows[i].e), 32'(e));
		end
		$display("test registers done");
		// a host fault, then five errors in five power states
		issue(4'hb, 4'h3, 1'b0);
		complete(1'b1, 1'b1, 8'hee);
		issue(4'ha, 4'h3, 1'b0);
		repeat (38) @(posedge pclk);
		for (int j = 0; j < 5; j++) begin
			issue(j[3:0], j[3:0], 1'b0);
			complete(1'b1, 1'b0, {4'hc, j[3:0]});
		end
		i_host.fetch(6'h00, sum);
		chk("sum", 32'h0, 32'(sum));
		chkb("index", 8'h05, 1);
		chkb("count", 8'h05, 452);
		for (int j = 0; j < 5; j++) chk_rec(2 + 90 * j, j[3:0], j[3:0], {4'hc, j[3:0]}, 1'b0);
		for (int i = 2; i < 26; i++) chkb("empty snap", 8'h00, i);
		chkb("third snap", 8'hb7, 33);
		chkb("prior snap", 8'h27, 315);
		chk("ms step", 32'ha, i_host.word(58) - i_host.word(46));
		i_host.fetch(6'h01, sum);
		chk("sum", 32'h0, 32'(sum));
		for (int i = 2; i < 452; i++) chkb("unused", 8'h00, i);
		$display("test records done");
		i_host.xfer(1'b1, A_ERRCNT, 32'hffff, r, e);
		complete(1'b1, 1'b0, 8'h99);
		i_host.xfer(1'b0, A_ERRCNT, 32'h0, r, e);
		chk("saturated", 32'hffff, r);
		$display("test saturation done");
		// fill the log, one more wraps to slot zero
		for (int k = 7; k < 257; k++) begin
			complete(1'b1, 1'b0, k[7:0] ^ 8'h5a);
			i_host.xfer(1'b0, A_STATUS, 32'h0, r, e);
			chk("index", (k > 255) ? 32'h1 : 32'(k), 32'(r[15:8]));
		end
		i_host.fetch(6'h00, sum);
		chkb("wrapped", 8'h5a, 63);
		chkb("kept", 8'hc1, 153);
		i_host.fetch(6'h32, sum);
		chk("sum", 32'h0, 32'(sum));
		chkb("last slot", 8'ha5, 423);
		$display("test wrap done");
		// power-on in mid-run: history empty, reset entry recorded
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		i_host.xfer(1'b0, A_STATUS, 32'h0, r, e);
		chk("status", 32'h0, r);
		i_host.xfer(1'b1, A_HOURS, 32'h1234, r, e);
		issue(4'h5, 4'h1, 1'b1);
		complete(1'b1, 1'b0, 8'h77);
		i_host.fetch(6'h00, sum);
		chk_rec(2, 4'h5, 4'h1, 8'h77, 1'b1);
		for (int i = 2; i < 50; i++) chkb("empty snap", 8'h00, i);
		$display("test power-on done");
		tally_and_finish();
	end
endmodule
